// [cdsd_core.sv]
// Compare-with-carry, decrement and signed divide datapath behind an APB slave.
// Assumes pclk at 125 MHz, async active-low presetn and a same-domain APB master.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module cdsd_core
    import cdsd_pkg::*;
#(
    parameter int CNT_W = 5
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pclk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy_o,
    output logic [16:0]      bus_addr_o,
    output logic             bus_fetch_o,
    output logic             mem_we_o,
    output logic             mem_byte_o,
    output logic [16:0]      mem_addr_o,
    output logic [15:0]      mem_wdata_o
);

    // Elaboration-time refusal: the longest divide needs 29 counts
    if (CNT_W < 5)
    begin : g_cnt_w_check
        $error("CNT_W too small for the divide cycle counts");
    end

    cdsd_state_t        state_r;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   cnt_nxt;
    logic [31:0]        ctrl_r;
    logic [15:0]        dest_r;
    logic [15:0]        src_r;
    logic [15:0]        impl_r;
    logic [15:0]        disp_r;
    logic [16:0]        opaddr_r;
    logic [16:0]        target_r;
    logic               taken_r;
    cdsd_flags_t        flags_r;
    logic [4:0]         last_cyc_r;
    logic [31:0]        prdata_r;
    logic [16:0]        bus_addr_r;
    logic               fetch_r;
    logic               mem_we_r;
    logic               mem_byte_r;
    logic [16:0]        mem_addr_r;
    logic [15:0]        mem_wdata_r;
    // Results of the divide, held until its final cycle
    logic [15:0]        pend_q_r;
    logic [15:0]        pend_r_r;
    logic               pend_ov_r;
    logic               pend_dimp_r;
    cdsd_flags_t        pend_flags_r;

    logic               apb_wr;
    logic               mapped;
    logic               start;
    logic               finish;
    cdsd_op_t           op;
    logic               is_byte;
    logic               is_mem;
    logic               is_dimp;
    logic [3:0]         code;

    assign op      = cdsd_op_t'(pwdata[CTRL_OP_LSB +: 3]);
    assign is_byte = pwdata[CTRL_BYTE];
    assign is_mem  = pwdata[CTRL_MEM];
    assign is_dimp = pwdata[CTRL_DIMP];
    assign code    = pwdata[CTRL_CODE_LSB +: 4];

    assign apb_wr = psel && penable && pwrite && pclk_en;
    always_comb
    begin
        unique case (paddr)
            ADDR_CTRL, ADDR_DEST, ADDR_SRC, ADDR_IMPL, ADDR_FLAGS,
            ADDR_STATUS, ADDR_OPADDR, ADDR_DISP, ADDR_TARGET: mapped = 1'b1;
            default:                                           mapped = 1'b0;
        endcase
    end
    // Starts while busy are dropped, not queued
    assign start  = apb_wr && (paddr == ADDR_CTRL) && pwdata[CTRL_START] && (state_r == st_idle);
    assign finish = (state_r == st_run) && (cnt_r == CNT_W'(1)) && pclk_en;

    assign pready  = pclk_en;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_r;
    assign busy_o  = (state_r == st_run);

    // ---------------- Compare path ----------------
    logic        cin;
    logic [16:0] cmp_diff;
    logic [15:0] cmp_res;
    cdsd_flags_t cmp_flags;
    always_comb
    begin
        cin = (op == op_compare_with_carry) ? flags_r.c : 1'b0;
        cmp_diff = {1'b0, dest_r} - ({1'b0, src_r} + {16'h0000, cin});
        cmp_res  = cmp_diff[15:0];
        cmp_flags.c = cmp_diff[16];
        cmp_flags.v = (dest_r[15] ^ src_r[15]) & (dest_r[15] ^ cmp_res[15]);
        cmp_flags.n = cmp_res[15];
        if (op == op_compare_with_carry)
            cmp_flags.z = (cmp_res != 16'h0000) ? 1'b0 : flags_r.z;
        else
            cmp_flags.z = (cmp_res == 16'h0000);
    end

    // ---------------- Decrement path ----------------
    logic [15:0] dec_opnd;
    logic [15:0] dec_res;
    cdsd_flags_t dec_flags;
    always_comb
    begin
        // byte operand zero-extended to a word
        dec_opnd = is_byte ? {8'h00, dest_r[7:0]} : dest_r;
        dec_res  = dec_opnd - 16'h0001;
        dec_flags.c = (dec_opnd == 16'h0000);
        // flags sized to byte or word
        if (is_byte)
        begin
            dec_flags.z = (dec_res[7:0] == 8'h00);
            dec_flags.n = dec_res[7];
            dec_flags.v = (dec_opnd[7:0] == 8'h80);
        end
        else
        begin
            dec_flags.z = (dec_res == 16'h0000);
            dec_flags.n = dec_res[15];
            dec_flags.v = (dec_opnd == 16'h8000);
        end
    end

    // ---------------- Branch target ----------------
    logic [15:0] dbnz_cnt;
    logic        dbnz_take;
    logic [16:0] dbnz_target;
    always_comb
    begin
        dbnz_cnt  = dest_r - 16'h0001;
        dbnz_take = (dbnz_cnt != 16'h0000);
        // byte offset 2*(2-code), from the 17-bit address
        // zero count goes to the next instruction
        if (dbnz_take)
            dbnz_target = opaddr_r + (DBNZ_BASE - {12'h000, code, 1'b0});
        else
            dbnz_target = opaddr_r + NEXT_OFS;
    end

    // ---------------- Signed divide path ----------------
    logic        div_long;
    logic [31:0] dvd;
    logic [31:0] dmag;
    logic [15:0] smag;
    logic [15:0] sdiv;
    logic        qsign;
    logic [32:0] lim_same;
    logic [32:0] lim_diff;
    logic        big;
    logic        ov;
    logic [31:0] qmag;
    logic [31:0] rmag;
    logic [15:0] quot;
    logic [15:0] rem;
    logic [4:0]  div_cyc;
    cdsd_flags_t div_flags;
    always_comb
    begin
        div_long = (op == op_signed_divide_long);
        dvd  = div_long ? {impl_r, dest_r} : {{16{dest_r[15]}}, dest_r};
        dmag = dvd[31] ? (32'h00000000 - dvd) : dvd;
        smag = src_r[15] ? (16'h0000 - src_r) : src_r;
        sdiv = (smag == 16'h0000) ? 16'h0001 : smag;
        qsign = src_r[15] ^ (div_long ? impl_r[15] : dest_r[15]);
        lim_same = {2'b00, smag, 15'h0000};
        lim_diff = lim_same + {17'h00000, smag};
        big      = ({1'b0, dmag} >= {1'b0, smag, 16'h0000});
        // zero divisor, long quotient out of range, or word minimum over -1
        if (div_long)
            ov = (src_r == 16'h0000) ||
                 ((src_r[15] == impl_r[15]) ? (lim_same <= {1'b0, dmag})
                                            : (lim_diff <= {1'b0, dmag}));
        else
            ov = (src_r == 16'h0000) || ((src_r == 16'hffff) && (dest_r == 16'h8000));
        qmag = dmag / {16'h0000, sdiv};
        rmag = dmag % {16'h0000, sdiv};
        quot = qsign ? (16'h0000 - qmag[15:0]) : qmag[15:0];
        rem  = dvd[31] ? (16'h0000 - rmag[15:0]) : rmag[15:0];
        // V, C, Z and N of the divide
        div_flags.v = ov;
        div_flags.c = 1'b0;
        div_flags.z = ov ? (src_r == 16'h0000) : (quot == 16'h0000);
        div_flags.n = ov ^ qsign;
        // word and long cycle counts with early exits
        if (!div_long)
            div_cyc = (src_r == 16'h0000) ? DIVW_ZERO_CYC :
                      ((src_r == 16'hffff) && (dest_r == 16'h8000)) ? DIVW_MIN_CYC : DIVW_CYC;
        else if (dvd == 32'h80000000)
            div_cyc = src_r[15] ? DIVL_MIN_NEG : DIVL_MIN_POS;
        else if (big)
            div_cyc = src_r[15] ? DIVL_BIG_NEG : DIVL_BIG_POS;
        else
            div_cyc = ov ? DIVL_OV_CYC : DIVL_CYC;
    end

    logic is_div;
    assign is_div = (op == op_signed_divide) || (op == op_signed_divide_long);

    // ---------------- Sequencer ----------------
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (start)
            cnt_nxt = is_div ? CNT_W'(div_cyc) : CNT_W'(ONE_CYC);
        else if (state_r == st_run)
            cnt_nxt = cnt_r - CNT_W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= st_idle;
            cnt_r      <= '0;
            last_cyc_r <= 5'h00;
        end
        else if (pclk_en)
        begin
            cnt_r <= cnt_nxt;
            unique case (state_r)
                st_idle:
                    if (start)
                    begin
                        state_r    <= st_run;
                        last_cyc_r <= is_div ? div_cyc : ONE_CYC;
                    end
                st_run:
                    if (cnt_r == CNT_W'(1))
                        state_r <= st_idle;
            endcase
        end
    end

    // idle bus, fetch of next instruction in last cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_addr_r <= ADDR_RST;
            fetch_r    <= 1'b0;
        end
        else if (pclk_en)
        begin
            fetch_r <= (cnt_nxt == CNT_W'(1)) && (start || (state_r == st_run));
            if ((cnt_nxt == CNT_W'(1)) && (start || (state_r == st_run)))
                bus_addr_r <= opaddr_r + NEXT_OFS;
        end
    end
    assign bus_addr_o  = bus_addr_r;
    assign bus_fetch_o = fetch_r;

    // ---------------- Divide results held to the end ----------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_q_r     <= WORD_RST;
            pend_r_r     <= WORD_RST;
            pend_ov_r    <= 1'b0;
            pend_dimp_r  <= 1'b0;
            pend_flags_r <= '0;
        end
        else if (pclk_en && start && is_div)
        begin
            pend_q_r     <= quot;
            pend_r_r     <= rem;
            pend_ov_r    <= ov;
            pend_dimp_r  <= is_dimp;
            pend_flags_r <= div_flags;
        end
    end

    // ---------------- Register file ----------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r   <= 32'h00000000;
            dest_r   <= WORD_RST;
            src_r    <= WORD_RST;
            impl_r   <= WORD_RST;
            disp_r   <= WORD_RST;
            opaddr_r <= ADDR_RST;
            target_r <= ADDR_RST;
            taken_r  <= 1'b0;
            flags_r  <= '0;
        end
        else if (pclk_en)
        begin
            if (finish && (ctrl_r[CTRL_OP_LSB +: 3] inside {op_signed_divide, op_signed_divide_long}))
            begin
                flags_r <= pend_flags_r;
                if (!pend_ov_r)
                begin
                    // quotient to dest, remainder to implied
                    // quotient overwrites remainder on a shared register
                    impl_r <= pend_dimp_r ? pend_q_r : pend_r_r;
                    if (!pend_dimp_r)
                        dest_r <= pend_q_r;
                end
            end
            else if (start)
            begin
                ctrl_r <= pwdata;
                unique case (op)
                    // carry and sticky zero chain the two halves
                    op_plain_compare, op_compare_with_carry:
                        flags_r <= cmp_flags;
                    op_decrement:
                    begin
                        flags_r <= dec_flags;
                        // register destination gets the whole word
                        if (!is_mem)
                            dest_r <= dec_res;
                    end
                    op_decrement_branch:
                    begin
                        dest_r   <= dbnz_cnt;
                        target_r <= dbnz_target;
                        taken_r  <= dbnz_take;
                    end
                    default:
                        ;
                endcase
            end
            else if (apb_wr && (state_r == st_idle))
            begin
                unique case (paddr)
                    ADDR_CTRL:   ctrl_r   <= pwdata;
                    ADDR_DEST:   dest_r   <= pwdata[15:0];
                    ADDR_SRC:    src_r    <= pwdata[15:0];
                    ADDR_IMPL:   impl_r   <= pwdata[15:0];
                    ADDR_FLAGS:  flags_r  <= cdsd_flags_t'(pwdata[3:0]);
                    ADDR_OPADDR: opaddr_r <= pwdata[16:0];
                    ADDR_DISP:   disp_r   <= pwdata[15:0];
                    default:     ;
                endcase
            end
        end
    end

    // memory destination at base plus displacement
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_we_r    <= 1'b0;
            mem_byte_r  <= 1'b0;
            mem_addr_r  <= ADDR_RST;
            mem_wdata_r <= WORD_RST;
        end
        else if (pclk_en)
        begin
            mem_we_r <= start && (op == op_decrement) && is_mem;
            if (start && (op == op_decrement) && is_mem)
            begin
                mem_byte_r  <= is_byte;
                mem_addr_r  <= {1'b0, src_r + disp_r};
                // byte writes carry only the low byte, word writes the whole word
                mem_wdata_r <= is_byte ? {8'h00, dec_res[7:0]} : dec_res;
            end
        end
    end
    assign mem_we_o    = mem_we_r;
    assign mem_byte_o  = mem_byte_r;
    assign mem_addr_o  = mem_addr_r;
    assign mem_wdata_o = mem_wdata_r;

    // Read data latched in the setup phase, so the access phase needs no wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h00000000;
        else if (pclk_en && psel && !penable)
        begin
            unique case (paddr)
                ADDR_CTRL:   prdata_r <= ctrl_r;
                ADDR_DEST:   prdata_r <= {16'h0000, dest_r};
                ADDR_SRC:    prdata_r <= {16'h0000, src_r};
                ADDR_IMPL:   prdata_r <= {16'h0000, impl_r};
                ADDR_FLAGS:  prdata_r <= {28'h0000000, flags_r};
                ADDR_STATUS: prdata_r <= {15'h0000, taken_r, 3'h0, last_cyc_r,
                                          7'h00, busy_o};
                ADDR_OPADDR: prdata_r <= {15'h0000, opaddr_r};
                ADDR_DISP:   prdata_r <= {16'h0000, disp_r};
                ADDR_TARGET: prdata_r <= {15'h0000, target_r};
                default:     prdata_r <= 32'h00000000;
            endcase
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge pclk iff pclk_en); endclocking
    default disable iff (!presetn);

    chk_compare_with_carry_zero_sticky: assert property (
        start && (op == op_compare_with_carry) |=>
            flags_r.z == (($past(cmp_res) == 16'h0000) && $past(flags_r.z)))
        else $error("compare-with-carry zero flag wrong");

    chk_cmp_no_write: assert property (
        start && (op inside {op_plain_compare, op_compare_with_carry}) |=>
            $stable(dest_r) && $stable(src_r) && $stable(impl_r))
        else $error("compare modified an operand");

    chk_cmp_borrow: assert property (
        start && (op == op_compare_with_carry) |=>
            flags_r.c == ({1'b0, $past(dest_r)} < ({1'b0, $past(src_r)} + {16'h0000, $past(flags_r.c)})))
        else $error("compare carry flag wrong");

    chk_dec_upper_byte: assert property (
        start && (op == op_decrement) && is_byte && !is_mem |=>
            dest_r[15:8] == (flags_r.c ? 8'hff : 8'h00))
        else $error("byte decrement upper byte wrong");

    chk_mem_low_byte: assert property (
        mem_we_o && mem_byte_o |-> mem_wdata_o[15:8] == 8'h00)
        else $error("byte memory write carries upper byte");

    chk_div_zero_len: assert property (
        start && (op == op_signed_divide) && (src_r == 16'h0000) |=>
            busy_o [*4] ##1 !busy_o)
        else $error("zero-divisor divide length wrong");

    chk_divl_min_len: assert property (
        start && (op == op_signed_divide_long) && (impl_r == 16'h8000) &&
        (dest_r == 16'h0000) && !src_r[15] |=> busy_o [*6] ##1 !busy_o)
        else $error("long divide early exit length wrong");

    chk_div_ov_keep: assert property (
        finish && pend_ov_r |=> $stable(dest_r) && $stable(impl_r) && $stable(src_r))
        else $error("overflowing divide changed a register");

    chk_div_flags: assert property (
        finish && (ctrl_r[2:0] inside {op_signed_divide, op_signed_divide_long}) |=>
            !flags_r.c && (flags_r.v == $past(pend_ov_r)))
        else $error("divide flags wrong");

    chk_final_fetch: assert property (
        finish |-> bus_fetch_o && (bus_addr_o == opaddr_r + NEXT_OFS))
        else $error("final cycle does not fetch");

    chk_dbnz_fall: assert property (
        start && (op == op_decrement_branch) && (dest_r == 16'h0001) |=>
            !taken_r && (target_r == $past(opaddr_r) + NEXT_OFS))
        else $error("branch taken on zero count");

    cov_compare_with_carry: cover property (start && (op == op_compare_with_carry));
    cov_div_word: cover property (finish && !pend_ov_r && (ctrl_r[2:0] == op_signed_divide));
    cov_divl_ov: cover property (finish && pend_ov_r && (ctrl_r[2:0] == op_signed_divide_long));
    cov_dbnz_taken: cover property (start && (op == op_decrement_branch) && dbnz_take);

endmodule : cdsd_core

// [cdsd_pkg.sv]
// Constants, types and register map of the compare/decrement/divide datapath.
// Assumes an APB master on pclk and a single clock domain.
package cdsd_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DEST   = 8'h04;
    localparam logic [7:0] ADDR_SRC    = 8'h08;
    localparam logic [7:0] ADDR_IMPL   = 8'h0c;
    localparam logic [7:0] ADDR_FLAGS  = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_OPADDR = 8'h18;
    localparam logic [7:0] ADDR_DISP   = 8'h1c;
    localparam logic [7:0] ADDR_TARGET = 8'h20;

    // Control field positions
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_BYTE     = 3;
    localparam int CTRL_MEM      = 4;
    localparam int CTRL_DIMP     = 5;
    localparam int CTRL_CODE_LSB = 8;
    localparam int CTRL_START    = 31;

    // Status field positions
    localparam int STAT_BUSY    = 0;
    localparam int STAT_CYC_LSB = 8;
    localparam int STAT_TAKEN   = 16;

    // Reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [16:0] ADDR_RST = 17'h00000;

    // Cycle counts of the divide and of the one-cycle ops
    localparam logic [4:0] DIVW_CYC      = 5'h1b;
    localparam logic [4:0] DIVW_ZERO_CYC = 5'h04;
    localparam logic [4:0] DIVW_MIN_CYC  = 5'h1a;
    localparam logic [4:0] DIVL_CYC      = 5'h1d;
    localparam logic [4:0] DIVL_MIN_POS  = 5'h06;
    localparam logic [4:0] DIVL_MIN_NEG  = 5'h07;
    localparam logic [4:0] DIVL_BIG_POS  = 5'h08;
    localparam logic [4:0] DIVL_BIG_NEG  = 5'h09;
    localparam logic [4:0] DIVL_OV_CYC   = 5'h1c;
    localparam logic [4:0] ONE_CYC       = 5'h01;

    // Branch and sequencing offsets in bytes
    localparam logic [16:0] NEXT_OFS   = 17'h00004;
    localparam logic [16:0] DBNZ_BASE  = 17'h00004;

    typedef enum logic [2:0] {
        op_plain_compare      = 3'h0,
        op_compare_with_carry = 3'h1,
        op_decrement          = 3'h2,
        op_signed_divide      = 3'h3,
        op_signed_divide_long = 3'h4,
        op_decrement_branch   = 3'h5
    } cdsd_op_t;

    typedef enum logic {
        st_idle = 1'b0,
        st_run  = 1'b1
    } cdsd_state_t;

    // Condition flags, packed as they sit in the flags register
    typedef struct packed {
        logic v;
        logic c;
        logic n;
        logic z;
    } cdsd_flags_t;

endpackage : cdsd_pkg

// [cdsd_tb.sv]
// Self-checking bench for the compare/decrement/divide core.
// Assumes a zero-wait APB slave and pclk_en held high except for three cycles in the freeze test.
`timescale 1ns/1ps
module testbench;
    import cdsd_pkg::*;
    logic        pclk = 0, presetn = 0, pclk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, busy_o, bus_fetch_o, mem_we_o, mem_byte_o, slv, we_s, mb_s, fe_s;
    logic [16:0] bus_addr_o, mem_addr_o, ma_s;
    logic [15:0] mem_wdata_o, wd_s;
    int          err_count = 0, checks = 0, cyc = 0, n;

    always #4 pclk = ~pclk;

    cdsd_core dut (.pclk, .presetn, .pclk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .busy_o, .bus_addr_o, .bus_fetch_o, .mem_we_o,
        .mem_byte_o, .mem_addr_o, .mem_wdata_o);

    task automatic final_report();
        if (err_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            final_report();
        end
    end

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(logic [7:0] a, logic [31:0] e, string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask : rdc

    // Starts an op and counts busy cycles; memory strobe seen in first one
    task automatic run(logic [31:0] c);
        apb(1'b1, ADDR_CTRL, 32'h8000_0000 | c);
        #1;
        we_s = mem_we_o;
        wd_s = mem_wdata_o;
        mb_s = mem_byte_o;
        ma_s = mem_addr_o;
        fe_s = 1'b0;
        n = 0;
        while (busy_o === 1'b1 && n < 64)
        begin
            fe_s = bus_fetch_o;
            @(posedge pclk);
            #1;
            n++;
        end
        chk("fetch_last", {30'h0, fe_s, bus_fetch_o}, 32'h2);
    endtask : run

    // Clock enable low for three cycles stretches a zero-divisor divide
    task automatic frz();
        apb(1'b1, ADDR_SRC, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h8000_0003);
        pclk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        pclk_en <= 1'b1;
        repeat (3) @(posedge pclk);
        #1;
        chk("frz_busy", busy_o, 1'b1);
        @(posedge pclk);
        #1;
        chk("frz_idle", busy_o, 1'b0);
    endtask : frz

    task automatic cmp32(logic [15:0] dl, sl, dh, sh, logic [31:0] ef);
        apb(1'b1, ADDR_FLAGS, 32'h0);
        apb(1'b1, ADDR_DEST, dl);
        apb(1'b1, ADDR_SRC, sl);
        run(op_plain_compare);
        apb(1'b1, ADDR_DEST, dh);
        apb(1'b1, ADDR_SRC, sh);
        run(op_compare_with_carry);
        rdc(ADDR_FLAGS, ef, "cmp32_flags");
        rdc(ADDR_DEST, dh, "compare_with_carry_dest");
    endtask : cmp32

    task automatic dec(logic [15:0] d, logic [31:0] c, logic [15:0] ed, logic [31:0] ef);
        apb(1'b1, ADDR_FLAGS, 32'h0);
        apb(1'b1, ADDR_DEST, d);
        run(c);
        rdc(ADDR_DEST, ed, "dec_dest");
        rdc(ADDR_FLAGS, ef, "dec_flags");
    endtask : dec

    // Carry preset so the divide must clear it
    task automatic div(logic [31:0] c, logic [15:0] i, d, s, logic [31:0] en, ei, ed, ef);
        apb(1'b1, ADDR_FLAGS, 32'h4);
        apb(1'b1, ADDR_IMPL, i);
        apb(1'b1, ADDR_DEST, d);
        apb(1'b1, ADDR_SRC, s);
        run(c);
        chk("div_cycles", n, en);
        rdc(ADDR_STATUS, en << 8, "div_status_cycles");
        rdc(ADDR_IMPL, ei, "div_impl");
        rdc(ADDR_DEST, ed, "div_dest");
        rdc(ADDR_FLAGS, ef, "div_flags");
    endtask : div

    task automatic dbnz(logic [15:0] d, logic [31:0] code, logic tk, logic [31:0] et);
        apb(1'b1, ADDR_OPADDR, 32'h100);
        apb(1'b1, ADDR_DEST, d);
        run(op_decrement_branch | (code << 8));
        rdc(ADDR_DEST, d - 16'h1, "dbnz_dest");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("dbnz_taken", rd[16], tk);
        rdc(ADDR_TARGET, et, "dbnz_target");
        chk("fetch_addr", bus_addr_o, 32'h104);
    endtask : dbnz

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(ADDR_FLAGS, 32'h0, "flags_rst");
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped_err", {31'h0, slv}, 32'h1);
        cmp32(16'h0000, 16'h0001, 16'h0005, 16'h0004, 32'h0);
        cmp32(16'h0007, 16'h0007, 16'h8000, 16'h0001, 32'h8);
        cmp32(16'h0007, 16'h0007, 16'h0004, 16'h0005, 32'h6);
        dec(16'h0100, op_decrement | 32'h8, 16'hffff, 32'h6);
        dec(16'h0001, op_decrement, 16'h0000, 32'h1);
        apb(1'b1, ADDR_SRC, 32'h10);
        apb(1'b1, ADDR_DISP, 32'h2);
        dec(16'h0080, op_decrement | 32'h18, 16'h0080, 32'h8);
        chk("mem_we", {mb_s, we_s, wd_s}, 32'h3007f);
        chk("mem_addr", ma_s, 32'h12);
        div(op_signed_divide, 16'h1234, 16'hfff9, 16'h2, 27, 16'hffff, 16'hfffd, 32'h2);
        div(op_signed_divide, 16'h5555, 16'h1234, 16'h0, 4, 16'h5555, 16'h1234, 32'hb);
        div(op_signed_divide, 16'h5555, 16'h8000, 16'hffff, 26, 16'h5555, 16'h8000, 32'ha);
        div(op_signed_divide_long, 16'hffff, 16'hfff9, 16'h2, 29, 16'hffff, 16'hfffd, 32'h2);
        div(op_signed_divide_long, 16'h8000, 16'h0, 16'h1, 6, 16'h8000, 16'h0, 32'h8);
        div(op_signed_divide_long, 16'h5, 16'h0, 16'h3, 8, 16'h5, 16'h0, 32'ha);
        div(op_signed_divide_long, 16'h1, 16'h8000, 16'h3, 28, 16'h1, 16'h8000, 32'ha);
        div(op_signed_divide_long | 32'h20, 16'h0, 16'h7, 16'h2, 29, 16'h3, 16'h7, 32'h0);
        dbnz(16'h0001, 32'h0, 1'b0, 32'h104);
        dbnz(16'h0002, 32'h0, 1'b1, 32'h104);
        dbnz(16'h0002, 32'hf, 1'b1, 32'he6);
        frz();
        final_report();
    end
endmodule : testbench
